// file: hdl/pcg_pkg.sv
// Purpose: shared constants for the clock generation and power mode block
// Assumes: one system clock at 125 MHz; clocks are modelled as enable pulses
// Notes: clock-out select and power mode codes are shared with the bench
package pcg_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8; // 125 MHz system clock
  localparam int REF_TIMEOUT_NS = 2000; // silent reference means lock lost
  // least wait, so round up
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LOCK_REFS = 8'h10; // reference edges to declare lock

  // ------------------------------------------------------------
  // clock-out fixed divisions (in source periods)
  // ------------------------------------------------------------
  localparam logic [1:0] OUT_DIV_CORE = 2'h2; // half of /4: toggle every 2 ticks
  localparam logic [1:0] OUT_DIV_SYS = 2'h1; // half of /2
  localparam logic [1:0] OUT_DIV_DRAM = 2'h1; // half of /2
  localparam logic [1:0] OUT_DIV_NONE = 2'h0; // pass the tick as is

  // ------------------------------------------------------------
  // divider indices and clock-out selection codes
  // ------------------------------------------------------------
  localparam int NCLK = 6;
  typedef enum logic [2:0] {
    PCG_SEL_CORE = 3'h0,
    PCG_SEL_SYS = 3'h1,
    PCG_SEL_PCLK_A = 3'h2,
    PCG_SEL_PCLK_B = 3'h3,
    PCG_SEL_DRAM = 3'h4,
    PCG_SEL_DIVIDED_OUTPUT_CLOCK = 3'h5,
    PCG_SEL_BUF = 3'h6
  } pcg_sel_t;

  // requested power mode
  typedef enum logic [1:0] {
    PCG_REQ_FULL = 2'h0,
    PCG_REQ_ACTIVE = 2'h1,
    PCG_REQ_SLEEP = 2'h2,
    PCG_REQ_HIB = 2'h3
  } pcg_req_t;

  // reset values of the settings
  localparam logic [7:0] RST_DIV = 8'h01;
  localparam logic [5:0] RST_MULT = 6'h01;
endpackage

// file: hdl/pcg_top.sv
// Purpose: clock generation unit with pll model, dividers, clock-out and power modes
// Assumes: reference_clock_in is slower than clk / (pll_mult + 2)
// Notes: every generated clock except clock_out_pin is a one-cycle enable pulse on clk
`timescale 1ns/1ps
module pcg_top #(
  parameter int DW = 8, // divisor width
  parameter int MW = 6 // multiplier width
) (
  // clock and reset (reset is the inverted hardware_reset_n)
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic reference_clock_in,
  input wire logic wake_in,
  output logic clock_out_pin,
  output logic regulator_wake,
  // settings and control
  input wire logic cfg_write,
  input wire logic [MW-1:0] pll_mult,
  input wire logic [DW-1:0] core_div,
  input wire logic [DW-1:0] sys_div,
  input wire logic [DW-1:0] pclk_a_div,
  input wire logic [DW-1:0] pclk_b_div,
  input wire logic [DW-1:0] dram_div,
  input wire logic [DW-1:0] divided_output_clock_div,
  input wire logic [2:0] clkout_sel,
  input wire logic [1:0] mode_req,
  input wire logic fault_reset_en,
  // clock enables
  output logic pll_output_clock,
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic peripheral_clock_a,
  output logic peripheral_clock_b,
  output logic dram_clock,
  output logic divided_output_clock,
  // status
  output logic cfg_pending,
  output logic pll_enabled,
  output logic pll_bypassed,
  output logic pll_locked,
  output logic dma_l1_allowed,
  output logic fault_reset_req,
  output logic [2:0] power_state
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (DW < 2 || MW < 1) begin : g_chk
    $error("pcg_top: divisor or multiplier width too small");
  end

  // ------------------------------------------------------------
  // types and declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_LOCK, ST_FULL, ST_ACTIVE, ST_UPDATE, ST_SLEEP, ST_HIB} pcg_st_t;

  pcg_st_t state_q; // power and update sequencer
  logic ref_s1_q, ref_s2_q, ref_s3_q; // reference synchroniser and edge stage
  logic wake_s1_q, wake_s2_q; // wake pin synchroniser
  logic ref_tick; // one pulse per reference rising edge
  logic [MW-1:0] burst_q; // pll pulses still owed for this reference period
  logic [MW-1:0] mult_q, pend_mult_q; // live and stored multiplier
  logic [DW-1:0] cur_div_q [pcg_pkg::NCLK]; // live divisors
  logic [DW-1:0] pend_div_q [pcg_pkg::NCLK]; // stored divisors
  logic [DW-1:0] in_div [pcg_pkg::NCLK]; // divisor inputs as array
  logic [DW-1:0] cnt_q [pcg_pkg::NCLK]; // divider counters
  logic [pcg_pkg::NCLK-1:0] tick_q; // divider outputs
  logic [2:0] sel_q, pend_sel_q; // live and stored clock-out select
  logic pend_q; // a stored setting waits
  logic apply; // settings taken over this cycle
  logic [7:0] lock_cnt_q; // reference edges seen since relock
  logic [15:0] silent_q; // cycles since last reference edge
  logic lock_lost; // pll lost its reference
  logic run; // clocks allowed to tick
  logic src_tick; // divider source: pll or reference
  logic pll_tick_q; // registered pll pulse
  logic [1:0] out_cnt_q; // clock-out divide counter
  logic [1:0] out_half; // ticks per clock-out toggle

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // divisor of zero behaves as one
  function automatic logic [DW-1:0] eff_div(input logic [DW-1:0] d);
    eff_div = (d == '0) ? DW'(1) : d;
  endfunction

  // half-period of the clock-out for each source
  function automatic logic [1:0] out_div(input logic [2:0] s);
    unique case (s)
      pcg_pkg::PCG_SEL_CORE: out_div = pcg_pkg::OUT_DIV_CORE;
      pcg_pkg::PCG_SEL_SYS: out_div = pcg_pkg::OUT_DIV_SYS;
      pcg_pkg::PCG_SEL_DRAM: out_div = pcg_pkg::OUT_DIV_DRAM;
      default: out_div = pcg_pkg::OUT_DIV_NONE;
    endcase
  endfunction

  assign in_div[0] = core_div;
  assign in_div[1] = sys_div;
  assign in_div[2] = pclk_a_div;
  assign in_div[3] = pclk_b_div;
  assign in_div[4] = dram_div;
  assign in_div[5] = divided_output_clock_div;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // two flops before use; third flop only feeds edge detect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= reference_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      wake_s1_q <= wake_in;
      wake_s2_q <= wake_s1_q;
    end
  end

  assign ref_tick = ref_s2_q & ~ref_s3_q;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  assign pll_enabled = (state_q != ST_SLEEP) && (state_q != ST_HIB);
  assign pll_bypassed = (state_q != ST_FULL);
  assign run = pll_enabled; // clocks stop in sleep and hibernate
  assign regulator_wake = (state_q != ST_HIB);
  assign dma_l1_allowed = (state_q == ST_FULL) || (state_q == ST_ACTIVE);
  assign power_state = state_q;
  assign apply = (state_q == ST_UPDATE) && ref_tick;
  assign cfg_pending = pend_q;
  assign pll_locked = (lock_cnt_q == pcg_pkg::LOCK_REFS);
  assign lock_lost = pll_locked && (silent_q == 16'(pcg_pkg::REF_TIMEOUT_CYC));

  // ------------------------------------------------------------
  // stored settings
  // ------------------------------------------------------------
  // a write only stores; a new write wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= cfg_write | (pend_q & ~apply);
    end
  end

  // stored copies of every setting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_mult_q <= pcg_pkg::RST_MULT;
      pend_sel_q <= pcg_pkg::PCG_SEL_BUF;
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        pend_div_q[i] <= pcg_pkg::RST_DIV;
      end
    end else if (cfg_write) begin
      pend_mult_q <= pll_mult;
      pend_sel_q <= clkout_sel;
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        pend_div_q[i] <= in_div[i];
      end
    end
  end

  // live settings: taken over only on a reference edge while bypassed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mult_q <= pcg_pkg::RST_MULT;
      sel_q <= pcg_pkg::PCG_SEL_BUF;
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        cur_div_q[i] <= pcg_pkg::RST_DIV;
      end
    end else if (apply) begin
      mult_q <= pend_mult_q;
      sel_q <= pend_sel_q;
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        cur_div_q[i] <= pend_div_q[i];
      end
    end
  end

  // ------------------------------------------------------------
  // power and update sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_LOCK; // lock first, then full-on
    end else begin
      unique case (state_q)
        ST_LOCK: begin
          if (pll_locked) begin
            state_q <= ST_FULL;
          end
        end
        ST_FULL, ST_ACTIVE: begin
          if (pend_q) begin
            state_q <= ST_UPDATE; // bypass while the pll retunes
          end else if (lock_lost) begin
            state_q <= ST_LOCK;
          end else if (mode_req == pcg_pkg::PCG_REQ_ACTIVE) begin
            state_q <= ST_ACTIVE;
          end else if (mode_req == pcg_pkg::PCG_REQ_SLEEP) begin
            state_q <= ST_SLEEP;
          end else if (mode_req == pcg_pkg::PCG_REQ_HIB) begin
            state_q <= ST_HIB;
          end else begin
            state_q <= ST_FULL;
          end
        end
        ST_UPDATE: begin
          if (apply) begin
            state_q <= ST_LOCK;
          end
        end
        ST_SLEEP: begin
          if (wake_s2_q) begin
            state_q <= ST_LOCK; // pll restarts from scratch
          end
        end
        ST_HIB: begin
          state_q <= ST_HIB; // only the hardware reset leaves
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pll model
  // ------------------------------------------------------------
  // each reference edge owes mult pulses, one per clk cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      burst_q <= '0;
      pll_tick_q <= 1'b0;
    end else begin
      pll_tick_q <= pll_enabled && (burst_q != '0);
      if (!pll_enabled) begin
        burst_q <= '0;
      end else if (ref_tick) begin
        burst_q <= mult_q;
      end else if (burst_q != '0) begin
        burst_q <= burst_q - MW'(1);
      end
    end
  end

  assign pll_output_clock = pll_tick_q;

  // lock: count reference edges; restart on retune or disable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_cnt_q <= '0;
    end else if (!pll_enabled || apply || lock_lost) begin
      lock_cnt_q <= '0;
    end else if (ref_tick && !pll_locked) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  // silence watchdog on the reference
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      silent_q <= '0;
    end else if (ref_tick || !pll_enabled) begin
      silent_q <= '0;
    end else if (silent_q != 16'(pcg_pkg::REF_TIMEOUT_CYC)) begin
      silent_q <= silent_q + 16'h0001;
    end
  end

  // fault: lock lost may request a hardware reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_reset_req <= 1'b0;
    end else begin
      fault_reset_req <= lock_lost && fault_reset_en;
    end
  end

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  // source is the reference while bypassed, else the pll
  assign src_tick = pll_bypassed ? ref_tick : pll_tick_q;

  // counters restart together on apply so no short pulse appears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_q <= '0;
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < pcg_pkg::NCLK; i++) begin
        tick_q[i] <= 1'b0;
        if (!run || apply) begin
          cnt_q[i] <= '0;
        end else if (src_tick) begin
          if (cnt_q[i] >= eff_div(cur_div_q[i]) - DW'(1)) begin
            cnt_q[i] <= '0;
            tick_q[i] <= 1'b1;
          end else begin
            cnt_q[i] <= cnt_q[i] + DW'(1);
          end
        end
      end
    end
  end

  assign core_clk_en = tick_q[0];
  assign sys_clk_en = tick_q[1];
  assign peripheral_clock_a = tick_q[2];
  assign peripheral_clock_b = tick_q[3];
  assign dram_clock = tick_q[4];
  assign divided_output_clock = tick_q[5];

  // ------------------------------------------------------------
  // clock-out pin
  // ------------------------------------------------------------
  assign out_half = out_div(sel_q);

  // buffered reference, passed tick, or toggle per half period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_out_pin <= 1'b0;
      out_cnt_q <= '0;
    end else if (sel_q == pcg_pkg::PCG_SEL_BUF) begin
      clock_out_pin <= ref_s2_q;
      out_cnt_q <= '0;
    end else if (sel_q > pcg_pkg::PCG_SEL_BUF) begin
      clock_out_pin <= 1'b0; // unused code parks low
      out_cnt_q <= '0;
    end else if (out_half == pcg_pkg::OUT_DIV_NONE) begin
      clock_out_pin <= tick_q[sel_q];
    end else if (tick_q[sel_q]) begin
      if (out_cnt_q >= out_half - 2'h1) begin
        out_cnt_q <= '0;
        clock_out_pin <= ~clock_out_pin;
      end else begin
        out_cnt_q <= out_cnt_q + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_update_done;
    (state_q == ST_UPDATE) && ref_tick ##1 (state_q == ST_LOCK);
  endsequence

  full_no_bypass_a: assert property ((state_q == ST_FULL) |-> pll_enabled && !pll_bypassed)
    else $error("full-on mode with pll bypassed or off");
  active_bypass_a: assert property ((state_q == ST_ACTIVE) && ref_tick |-> pll_bypassed && src_tick)
    else $error("active mode not clocked from the reference");
  sleep_stops_a: assert property ($past(state_q == ST_SLEEP) && (state_q == ST_SLEEP)
    |-> !pll_output_clock && (tick_q == '0))
    else $error("clock pulse during deep sleep");
  hib_regulator_a: assert property ((state_q == ST_HIB) |=> !regulator_wake && (tick_q == '0))
    else $error("hibernate left regulator on or clocks running");
  write_no_change_a: assert property (cfg_write && (state_q == ST_FULL)
    |=> $stable(mult_q) && $stable(sel_q) && pend_q)
    else $error("settings write took effect at once");
  update_relock_a: assert property (s_update_done |-> !pll_locked ##1 (state_q == ST_LOCK))
    else $error("settings applied without relock");
  lock_to_full_a: assert property ((state_q == ST_LOCK) && pll_locked |=> (state_q == ST_FULL))
    else $error("lock finished but full-on not entered");
  buf_out_a: assert property ((sel_q == pcg_pkg::PCG_SEL_BUF)
    ##1 (sel_q == pcg_pkg::PCG_SEL_BUF) |-> clock_out_pin == $past(ref_s2_q))
    else $error("clock-out does not follow reference");
  fault_req_a: assert property (lock_lost && fault_reset_en |=> fault_reset_req ##1 !pll_locked)
    else $error("lost lock did not request reset");
  // a sleep or hibernate entry right after the edge legally cuts the burst
  pll_burst_a: assert property (ref_tick && pll_enabled && (mult_q == MW'(1))
    ##1 pll_enabled |-> ##1 pll_output_clock ##1 !pll_output_clock)
    else $error("pll pulse count wrong for multiplier one");
endmodule

// file: verif/test_pcg_top.sv
// Purpose: self-checking bench for the clock generation and power mode block
// Assumes: reference pin toggles every 10 clk cycles, a 160 ns period
// Notes: enables are counted over whole reference periods, so counts are exact
`timescale 1ns/1ps
module test_pcg_top;
  // ------------------------------------------------------------
  // power state codes as handed over
  // ------------------------------------------------------------
  localparam logic [2:0] ST_LOCK = 3'h0;
  localparam logic [2:0] ST_FULL = 3'h1;
  localparam logic [2:0] ST_ACT = 3'h2;
  localparam logic [2:0] ST_SLEEP = 3'h4;
  localparam logic [2:0] ST_HIB = 3'h5;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, reset, reference_clock_in, wake_in, cfg_write, fault_reset_en;
  logic [5:0] pll_mult;
  logic [7:0] core_div, sys_div, pclk_a_div, pclk_b_div, dram_div, divided_output_clock_div;
  logic [2:0] clkout_sel, power_state;
  logic [1:0] mode_req;
  logic clock_out_pin, regulator_wake, pll_output_clock, core_clk_en, sys_clk_en;
  logic peripheral_clock_a, peripheral_clock_b, dram_clock, divided_output_clock;
  logic cfg_pending, pll_enabled, pll_bypassed, pll_locked, dma_l1_allowed;
  logic fault_reset_req;
  logic ref_run; // stops the reference to fake a lost lock
  int ref_div = 0;
  int cnt [10]; // 0 ref rise, 1 pll, 2..7 dividers, 8 out rise, 9 out toggle
  logic ref_p, out_p;
  int failures = 0;
  int num_checks = 0;

  pcg_top DUT (
    .clk(clk), .reset(reset), .reference_clock_in(reference_clock_in),
    .wake_in(wake_in), .clock_out_pin(clock_out_pin), .regulator_wake(regulator_wake),
    .cfg_write(cfg_write), .pll_mult(pll_mult), .core_div(core_div), .sys_div(sys_div),
    .pclk_a_div(pclk_a_div), .pclk_b_div(pclk_b_div), .dram_div(dram_div),
    .divided_output_clock_div(divided_output_clock_div), .clkout_sel(clkout_sel), .mode_req(mode_req),
    .fault_reset_en(fault_reset_en), .pll_output_clock(pll_output_clock),
    .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en),
    .peripheral_clock_a(peripheral_clock_a), .peripheral_clock_b(peripheral_clock_b),
    .dram_clock(dram_clock), .divided_output_clock(divided_output_clock),
    .cfg_pending(cfg_pending), .pll_enabled(pll_enabled), .pll_bypassed(pll_bypassed),
    .pll_locked(pll_locked), .dma_l1_allowed(dma_l1_allowed),
    .fault_reset_req(fault_reset_req), .power_state(power_state)
  );

  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // reference source; non-blocking so the monitor sees the old level
  always @(negedge clk) begin
    if (ref_run) begin
      if (ref_div == 9) begin
        ref_div <= 0;
        reference_clock_in <= ~reference_clock_in;
      end else begin
        ref_div <= ref_div + 1;
      end
    end
  end

  // event counters, sampled at the falling edge where outputs are settled
  always @(negedge clk) begin : mon
    logic [9:0] ev;
    ev = {clock_out_pin !== out_p, clock_out_pin === 1'b1 && out_p === 1'b0,
          divided_output_clock, dram_clock, peripheral_clock_b, peripheral_clock_a,
          sys_clk_en, core_clk_en, pll_output_clock,
          reference_clock_in === 1'b1 && ref_p === 1'b0};
    // an unknown enable would otherwise count as silence
    if ($isunknown(ev)) begin
      failures++;
      $display("BAD t=%0t unknown clock output", $time);
    end
    for (int i = 0; i < 10; i++) if (ev[i] === 1'b1) cnt[i]++;
    ref_p = reference_clock_in;
    out_p = clock_out_pin;
  end

  // ------------------------------------------------------------
  // compare, wait and report
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check_lv(input logic [2:0] got, input logic [2:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp, input string msg);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  // counters are read at the rising edge, away from their update
  task automatic wait_ref();
    int s;
    s = cnt[0];
    for (int i = 0; i < 100 && cnt[0] == s; i++) @(posedge clk);
    if (cnt[0] == s) begin
      failures++;
      $display("BAD t=%0t reference edge never seen", $time);
      results();
    end
  endtask

  // event counts over k reference periods
  task automatic measure(input int k, output int d [10]);
    int s [10];
    wait_ref();
    s = cnt;
    repeat (k) wait_ref();
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask

  task automatic wait_state(input logic [2:0] s);
    int i;
    for (i = 0; i < 3000 && power_state !== s; i++) @(negedge clk);
    if (power_state !== s) begin
      failures++;
      $display("BAD t=%0t state %h never reached", $time, s);
      results();
    end
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
  endtask

  // store settings just after a reference edge, then wait for relock
  task automatic apply(input logic [7:0] cd, input logic [7:0] dd, input logic [2:0] sel);
    wait_ref();
    @(negedge clk);
    pll_mult = 6'h03;
    core_div = cd;
    sys_div = cd;
    pclk_a_div = cd;
    pclk_b_div = cd;
    dram_div = dd;
    divided_output_clock_div = dd;
    clkout_sel = sel;
    cfg_write = 1'b1;
    @(negedge clk);
    cfg_write = 1'b0;
    @(negedge clk);
    check_lv(3'(cfg_pending), 3'h1, "setting not held");
    check_lv(3'(pll_locked), 3'h1, "lock dropped at write");
    wait_state(ST_LOCK);
    wait_state(ST_FULL);
    check_lv(3'(cfg_pending), 3'h0, "setting still pending");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    int d [10];
    @(negedge clk);
    check_lv(power_state, ST_LOCK, "state after reset");
    check_lv({regulator_wake, pll_enabled, dma_l1_allowed}, 3'h6, "levels after reset");
    measure(4, d);
    check_cnt(d[8], 4, "buffered reference on clock-out");
    wait_state(ST_FULL);
    check_lv({pll_enabled, pll_bypassed}, 3'h2, "full-on pll use");
  endtask

  // mult 3, divide 2 and 3, clock-out on the core clock
  task automatic t_divide();
    int d [10];
    apply(8'h02, 8'h03, pcg_pkg::PCG_SEL_CORE);
    measure(8, d);
    check_cnt(d[1], 24, "pll pulses");
    check_cnt(d[2], 12, "core pulses");
    check_cnt(d[3] + d[4] + d[5], 36, "system and peripheral pulses");
    check_cnt(d[6] + d[7], 16, "dram and output pulses");
    check_cnt(d[9], 6, "core on clock-out");
  endtask

  // every other divider clock-out source; toggles for /2, rises for pass-through
  task automatic t_clkout();
    int d [10];
    pcg_pkg::pcg_sel_t sel [5];
    int idx [5];
    int exp [5];
    sel = '{pcg_pkg::PCG_SEL_SYS, pcg_pkg::PCG_SEL_DRAM, pcg_pkg::PCG_SEL_PCLK_A,
            pcg_pkg::PCG_SEL_PCLK_B, pcg_pkg::PCG_SEL_DIVIDED_OUTPUT_CLOCK};
    idx = '{9, 9, 8, 8, 8};
    exp = '{12, 8, 12, 12, 8};
    for (int i = 0; i < 5; i++) begin
      apply(8'h02, 8'h03, sel[i]);
      measure(8, d);
      check_cnt(d[idx[i]], exp[i], "clock-out source rate");
    end
  endtask

  // active: bypassed, core runs from reference ticks over core_div 2
  task automatic t_active();
    int d [10];
    @(negedge clk);
    mode_req = pcg_pkg::PCG_REQ_ACTIVE;
    wait_state(ST_ACT);
    check_lv({pll_bypassed, dma_l1_allowed}, 3'h3, "active levels");
    measure(8, d);
    check_cnt(d[2], 4, "core at reference rate");
    @(negedge clk);
    mode_req = pcg_pkg::PCG_REQ_FULL;
    wait_state(ST_FULL);
    check_lv(3'(pll_bypassed), 3'h0, "back to full-on");
  endtask

  task automatic t_sleep();
    int d [10];
    mode_req = pcg_pkg::PCG_REQ_SLEEP;
    wait_state(ST_SLEEP);
    mode_req = pcg_pkg::PCG_REQ_FULL;
    check_lv({pll_enabled, regulator_wake}, 3'h1, "sleep levels");
    measure(4, d);
    check_cnt(d[1] + d[2] + d[3] + d[4] + d[5] + d[6], 0, "clocks in sleep");
    @(negedge clk);
    wake_in = 1'b1;
    wait_state(ST_LOCK);
    wake_in = 1'b0;
    wait_state(ST_FULL);
  endtask

  task automatic t_hib();
    int d [10];
    mode_req = pcg_pkg::PCG_REQ_HIB;
    wait_state(ST_HIB);
    mode_req = pcg_pkg::PCG_REQ_FULL;
    check_lv(3'(regulator_wake), 3'h0, "regulator wake in hibernate");
    measure(4, d);
    check_cnt(d[1] + d[2] + d[3] + d[6] + d[7], 0, "clocks in hibernate");
    @(negedge clk);
    do_reset();
    wait_state(ST_FULL);
  endtask

  // silent reference while locked gives one fault pulse
  task automatic t_fault();
    int hits;
    hits = 0;
    fault_reset_en = 1'b1;
    ref_run = 1'b0;
    repeat (400) begin
      @(negedge clk);
      if (fault_reset_req === 1'b1) hits++;
    end
    check_cnt(hits, 1, "fault reset pulses");
    ref_run = 1'b1;
    wait_state(ST_FULL);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reference_clock_in = 1'b0;
    ref_run = 1'b1;
    wake_in = 1'b0;
    cfg_write = 1'b0;
    fault_reset_en = 1'b0;
    pll_mult = 6'h01;
    {core_div, sys_div, pclk_a_div, pclk_b_div, dram_div, divided_output_clock_div} = {6{8'h01}};
    clkout_sel = pcg_pkg::PCG_SEL_BUF;
    mode_req = pcg_pkg::PCG_REQ_FULL;
    do_reset();
    t_reset();
    t_divide();
    t_clkout();
    t_active();
    t_sleep();
    t_fault();
    t_hib();
    results();
  end
endmodule
